// File: rtl/pmsm_ctrl.sv
/*
 * Operating-mode controller: one encoded state and the per-function enables derived from it.
 * Assumes the SPI decoder, wake detectors, watchdog and supply monitors sit outside and
 * deliver one-cycle event pulses synchronous to clock_i.
 */
module pmsm_ctrl
    import pmsm_pkg::*;
#(
    parameter logic [TMR_W-1:0] FS_FILTER_CYC = TMR_W'(FAILSAFE_FILTER_CYC),
    parameter logic [TMR_W-1:0] OT_RECOV_CYC  = TMR_W'(OVERTEMP_RECOVERY_CYC)
) (
    // Clock and reset.
    input  wire logic      clock_i,
    input  wire logic      sys_rst_i,
    // Straps and host commands.
    input  wire logic      devmode_strap_i,
    input  wire logic      spi_frame_i,
    input  wire logic      spi_content_bad_i,
    input  wire logic      mode_wr_i,
    input  wire logic [1:0] mode_code_i,
    input  wire pmsm_cfg_t normal_cfg_i,
    input  wire logic      softreset_pin_suppress_i,
    input  wire logic      devmode_watchdog_off_i,
    input  wire logic      devmode_watchdog_irq_mask_i,
    input  wire logic      status_clr_i,
    // Events.
    input  wire logic      wake_event_i,
    input  wire logic      can_bus_wake_i,
    input  wire logic      brake_request_i,
    input  wire logic      restart_fault_i,
    input  wire logic      failsafe_fault_i,
    input  wire logic      reg_short_gnd_i,
    input  wire logic      regulator_overtemp_shutdown_i,
    input  wire logic      regulator_ok_i,
    input  wire logic      wd_fault_i,
    // Outputs.
    output pmsm_state_t    state_o,
    output pmsm_en_t       enables_o,
    output logic           reset_out_n_o,
    output logic           interrupt_out_n_o,
    output logic           interrupt_oe_o,
    output logic           devmode_o,
    output logic           default_wake_en_o,
    output logic           wake_flags_clr_o,
    output logic           watchdog_trigger_fault_o,
    output logic           command_fault_o,
    output logic           device_failure_o
);

    // ==========================================================================
    // State and held flags.
    pmsm_state_t state_r;
    pmsm_state_t state_nxt;
    logic        devmode_r;
    logic        init_seen_r;
    logic        wake_stored_r;
    logic        ot_seen_r;
    logic        can_woken_r;
    logic        first_normal_r;
    logic [4:0]  rst_pulse_r;
    logic        wd_irq;
    logic        wd_mode_fault;
    logic        fs_done;
    logic        ot_done;
    logic        fs_entry;
    logic        soft_reset;
    logic        leave_fs;
    pmsm_en_t    en_nxt;

    function automatic logic is_cmd(input logic wr, input logic [1:0] code, input logic [1:0] c);
        is_cmd = wr && (code == c);
    endfunction

    // ==========================================================================
    // Helpers.
    pmsm_devwd u_devwd (
        .clock_i                     (clock_i),
        .sys_rst_i                   (sys_rst_i),
        .devmode_i                   (devmode_r),
        .wd_fault_i                  (wd_fault_i),
        .devmode_watchdog_off_i      (devmode_watchdog_off_i),
        .devmode_watchdog_irq_mask_i (devmode_watchdog_irq_mask_i),
        .fault_clr_i                 (status_clr_i),
        .watchdog_trigger_fault_o    (watchdog_trigger_fault_o),
        .irq_pulse_o                 (wd_irq),
        .mode_fault_o                (wd_mode_fault)
    );

    assign fs_entry = (state_nxt == PMSM_FAILSAFE) && (state_r != PMSM_FAILSAFE);

    pmsm_timer u_fs_timer (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (fs_entry),
        .run_i     (state_r == PMSM_FAILSAFE),
        .load_i    (FS_FILTER_CYC),
        .done_o    (fs_done)
    );

    pmsm_timer u_ot_timer (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (fs_entry | regulator_overtemp_shutdown_i),
        .run_i     (state_r == PMSM_FAILSAFE && ot_seen_r),
        .load_i    (OT_RECOV_CYC),
        .done_o    (ot_done)
    );

    // ==========================================================================
    // Next state.
    assign soft_reset = is_cmd(mode_wr_i, mode_code_i, MODE_CMD_SOFTRST)
                        && (state_r == PMSM_NORMAL || state_r == PMSM_STOP);

    assign leave_fs = (state_r == PMSM_FAILSAFE) && (state_nxt != PMSM_FAILSAFE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMSM_INIT: begin
                if (failsafe_fault_i || reg_short_gnd_i) begin
                    state_nxt = PMSM_FAILSAFE;
                end else if (spi_frame_i) begin
                    state_nxt = PMSM_NORMAL;
                end
            end
            PMSM_NORMAL, PMSM_STOP: begin
                if (failsafe_fault_i) begin
                    state_nxt = PMSM_FAILSAFE;
                end else if (restart_fault_i || wd_mode_fault) begin
                    state_nxt = PMSM_RESTART;
                end else if (soft_reset) begin
                    state_nxt = PMSM_INIT;
                end else if (is_cmd(mode_wr_i, mode_code_i, MODE_CMD_STOP)
                             && state_r == PMSM_NORMAL) begin
                    state_nxt = PMSM_STOP;
                end else if (is_cmd(mode_wr_i, mode_code_i, MODE_CMD_SLEEP)) begin
                    state_nxt = (state_r == PMSM_NORMAL) ? PMSM_SLEEP : PMSM_RESTART;
                end else if (is_cmd(mode_wr_i, mode_code_i, MODE_CMD_NORMAL)) begin
                    state_nxt = PMSM_NORMAL;
                end
            end
            PMSM_SLEEP: begin
                if (failsafe_fault_i) begin
                    state_nxt = PMSM_FAILSAFE;
                end else if (wake_event_i || can_bus_wake_i) begin
                    state_nxt = PMSM_RESTART;
                end
            end
            PMSM_RESTART: begin
                if (failsafe_fault_i) begin
                    state_nxt = PMSM_FAILSAFE;
                end else if (regulator_ok_i) begin
                    state_nxt = PMSM_NORMAL;
                end
            end
            PMSM_FAILSAFE: begin
                if (fs_done && wake_stored_r) begin
                    state_nxt = PMSM_RESTART;
                end else if (ot_done && ot_seen_r && !regulator_overtemp_shutdown_i) begin
                    state_nxt = PMSM_RESTART;
                end
            end
            default: state_nxt = PMSM_INIT;
        endcase
    end

    // ==========================================================================
    // Enable decode from the next-state value, registered alongside the state.
    always_comb begin
        en_nxt = EN_ALL_OFF;
        case (state_nxt)
            PMSM_INIT: begin
                en_nxt.main_regulator = 1'b1;
                en_nxt.watchdog_unit  = 1'b1;
                en_nxt.can_on         = devmode_r;
            end
            PMSM_NORMAL: begin
                en_nxt.main_regulator        = 1'b1;
                en_nxt.watchdog_unit         = normal_cfg_i.watchdog_unit
                                               && !(devmode_r && devmode_watchdog_off_i);
                en_nxt.high_side_switches    = normal_cfg_i.high_side_switches;
                en_nxt.bridge_drive_and_pump = normal_cfg_i.bridge_drive_and_pump;
                en_nxt.current_sense_amp     = normal_cfg_i.current_sense_amp;
                en_nxt.cyclic_sense          = normal_cfg_i.cyclic_sense;
                en_nxt.cyclic_wake           = normal_cfg_i.cyclic_wake;
                en_nxt.can_on                = normal_cfg_i.can_on
                                               || (devmode_r && first_normal_r);
                en_nxt.can_wake_capable      = normal_cfg_i.can_wake_capable;
                en_nxt.parking_brake         = 1'b1;
            end
            PMSM_STOP: begin
                en_nxt.main_regulator     = 1'b1;
                en_nxt.watchdog_unit      = normal_cfg_i.watchdog_unit
                                            && !(devmode_r && devmode_watchdog_off_i);
                en_nxt.high_side_switches = normal_cfg_i.high_side_switches;
                en_nxt.cyclic_sense       = normal_cfg_i.cyclic_sense;
                en_nxt.cyclic_wake        = normal_cfg_i.cyclic_wake;
                en_nxt.can_on             = normal_cfg_i.can_on;
                en_nxt.can_wake_capable   = normal_cfg_i.can_wake_capable;
                en_nxt.low_side_brake     = brake_request_i;
                en_nxt.parking_brake      = 1'b1;
            end
            PMSM_SLEEP: begin
                en_nxt.high_side_switches = normal_cfg_i.high_side_switches;
                en_nxt.cyclic_sense       = normal_cfg_i.cyclic_sense;
                en_nxt.cyclic_wake        = normal_cfg_i.cyclic_wake;
                en_nxt.can_wake_capable   = normal_cfg_i.can_wake_capable;
                en_nxt.low_side_brake     = brake_request_i;
                en_nxt.parking_brake      = 1'b1;
            end
            PMSM_RESTART: begin
                en_nxt.main_regulator   = 1'b1;
                en_nxt.can_on           = can_woken_r;
                en_nxt.can_wake_capable = normal_cfg_i.can_wake_capable;
            end
            PMSM_FAILSAFE: begin
                en_nxt.can_wake_capable = 1'b1;
            end
            default: en_nxt = EN_ALL_OFF;
        endcase
    end

    // ==========================================================================
    // Registers.
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r         <= PMSM_INIT;
            enables_o       <= EN_ALL_OFF;
            devmode_r       <= 1'b0;
            init_seen_r     <= 1'b0;
            first_normal_r  <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            enables_o <= en_nxt;
            init_seen_r <= 1'b1;
            if (state_r == PMSM_INIT && reg_short_gnd_i) begin
                devmode_r <= 1'b0;
            end else if (!init_seen_r) begin
                devmode_r <= devmode_strap_i;
            end
            if (state_r == PMSM_NORMAL && state_nxt != PMSM_NORMAL) begin
                first_normal_r <= 1'b0;
            end else if (state_nxt == PMSM_INIT && state_r != PMSM_INIT) begin
                first_normal_r <= 1'b1;
            end
        end
    end

    // The wake store drops on entry so events before fail-safe cannot shorten the filter.
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wake_stored_r     <= 1'b0;
            ot_seen_r         <= 1'b0;
            can_woken_r       <= 1'b0;
            default_wake_en_o <= 1'b0;
            wake_flags_clr_o  <= 1'b0;
        end else begin
            wake_stored_r     <= !fs_entry && (wake_stored_r || wake_event_i
                                 || can_bus_wake_i) && state_nxt == PMSM_FAILSAFE;
            ot_seen_r         <= (regulator_overtemp_shutdown_i || ot_seen_r)
                                 && state_nxt == PMSM_FAILSAFE;
            can_woken_r       <= (can_woken_r || can_bus_wake_i) && state_nxt != PMSM_NORMAL;
            default_wake_en_o <= (state_nxt == PMSM_FAILSAFE) || (default_wake_en_o
                                 && state_nxt != PMSM_NORMAL);
            wake_flags_clr_o  <= fs_entry;
        end
    end

    // ==========================================================================
    // Pins and status.
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_pulse_r       <= '0;
            reset_out_n_o     <= 1'b0;
            interrupt_out_n_o <= 1'b1;
            interrupt_oe_o    <= 1'b0;
            command_fault_o   <= 1'b0;
            device_failure_o  <= 1'b0;
        end else begin
            if (soft_reset && !softreset_pin_suppress_i) begin
                rst_pulse_r <= 5'(SOFTRST_PULSE_CYC);
            end else if (rst_pulse_r != '0) begin
                rst_pulse_r <= rst_pulse_r - 5'h01;
            end
            reset_out_n_o <= !(state_nxt == PMSM_RESTART || state_nxt == PMSM_SLEEP
                               || state_nxt == PMSM_FAILSAFE
                               || (soft_reset && !softreset_pin_suppress_i)
                               || rst_pulse_r > 5'h01);
            interrupt_oe_o    <= interrupt_oe_o || (state_r == PMSM_INIT
                                                    && state_nxt == PMSM_NORMAL);
            interrupt_out_n_o <= !(wd_irq && interrupt_oe_o);
            command_fault_o   <= (state_r == PMSM_INIT && spi_frame_i && spi_content_bad_i)
                                 || (command_fault_o && !status_clr_i);
            device_failure_o  <= leave_fs || (device_failure_o && !status_clr_i);
        end
    end

    assign state_o   = state_r;
    assign devmode_o = devmode_r;

endmodule

// File: pkg/pmsm_pkg.sv
/*
 * Shared constants, state encoding and carrier structs of the operating-mode controller.
 * Assumes a single 50 MHz clock; all other inputs are already synchronous to it.
 */
package pmsm_pkg;

    // ==========================================================================
    // Timing.
    localparam int unsigned CLK_HZ                  = 50_000_000;
    localparam int unsigned FAILSAFE_FILTER_TIME_MS = 100;
    localparam int unsigned OVERTEMP_RECOVERY_TIME_MS = 1000;
    localparam int unsigned FAILSAFE_FILTER_CYC     = (CLK_HZ / 1000) * FAILSAFE_FILTER_TIME_MS;
    localparam int unsigned OVERTEMP_RECOVERY_CYC   = (CLK_HZ / 1000) * OVERTEMP_RECOVERY_TIME_MS;
    localparam int unsigned SOFTRST_PULSE_CYC       = 16;
    localparam int unsigned TMR_W                   = 26;

    // ==========================================================================
    // Mode command codes.
    localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CMD_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_CMD_STOP   = 2'h2;
    localparam logic [1:0] MODE_CMD_SOFTRST = 2'h3;

    // ==========================================================================
    // Operating states.
    typedef enum logic [2:0] {
        PMSM_INIT     = 3'h0,
        PMSM_NORMAL   = 3'h1,
        PMSM_STOP     = 3'h2,
        PMSM_SLEEP    = 3'h3,
        PMSM_RESTART  = 3'h4,
        PMSM_FAILSAFE = 3'h5
    } pmsm_state_t;

    // ==========================================================================
    // Carriers.
    typedef struct packed {
        logic high_side_switches;
        logic cyclic_sense;
        logic cyclic_wake;
        logic bridge_drive_and_pump;
        logic current_sense_amp;
        logic can_on;
        logic can_wake_capable;
        logic watchdog_unit;
    } pmsm_cfg_t;

    typedef struct packed {
        logic main_regulator;
        logic watchdog_unit;
        logic high_side_switches;
        logic bridge_drive_and_pump;
        logic current_sense_amp;
        logic cyclic_sense;
        logic cyclic_wake;
        logic can_on;
        logic can_wake_capable;
        logic low_side_brake;
        logic parking_brake;
    } pmsm_en_t;

    localparam pmsm_en_t EN_ALL_OFF = '0;

endpackage

// File: rtl/pmsm_timer.sv
/*
 * Down-counter that is reloaded on a start pulse and flags when it has run out.
 * Assumes start is a one-cycle pulse from the mode controller.
 */
module pmsm_timer
    import pmsm_pkg::*;
(
    // Clock and reset.
    input  wire logic             clock_i,
    input  wire logic             sys_rst_i,
    // Control.
    input  wire logic             start_i,
    input  wire logic             run_i,
    input  wire logic [TMR_W-1:0] load_i,
    // Status.
    output logic                  done_o
);

    // ==========================================================================
    // Counter.
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic             done_nxt;

    assign cnt_nxt  = start_i ? load_i : ((run_i && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
    assign done_nxt = !start_i && run_i && (cnt_r <= TMR_W'(1));

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r  <= '0;
            done_o <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_o <= done_nxt;
        end
    end

endmodule

// File: rtl/pmsm_devwd.sv
/*
 * Watchdog fault reporting of the standard and the software development variant.
 * Assumes wd_fault_i is a one-cycle pulse per wrong watchdog trigger.
 */
module pmsm_devwd
    import pmsm_pkg::*;
(
    // Clock and reset.
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    // Inputs.
    input  wire logic devmode_i,
    input  wire logic wd_fault_i,
    input  wire logic devmode_watchdog_off_i,
    input  wire logic devmode_watchdog_irq_mask_i,
    input  wire logic fault_clr_i,
    // Outputs.
    output logic      watchdog_trigger_fault_o,
    output logic      irq_pulse_o,
    output logic      mode_fault_o
);

    // ==========================================================================
    // Reporting.
    logic live;
    logic flag_nxt;

    assign live     = wd_fault_i && !(devmode_i && devmode_watchdog_off_i);
    assign flag_nxt = live | (watchdog_trigger_fault_o & ~fault_clr_i);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_trigger_fault_o <= 1'b0;
            irq_pulse_o              <= 1'b0;
            mode_fault_o             <= 1'b0;
        end else begin
            watchdog_trigger_fault_o <= flag_nxt;
            irq_pulse_o  <= live && devmode_i && !devmode_watchdog_irq_mask_i;
            mode_fault_o <= wd_fault_i && !devmode_i;
        end
    end

endmodule

// File: dv/pmsm_host_model.sv
/* Behavioural host microcontroller that issues SPI frames and mode writes.
   Assumes the device's reset pin gates the host: no frame leaves while it is low, for up to 200 cycles. */
module pmsm_host_model
    import pmsm_pkg::*;
(
    // Pins from the device.
    input  wire logic  clock_i,
    input  wire logic  reset_out_n_i,
    // Strobes {frame, content bad, mode write, mode code}.
    output logic [4:0] cmd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cmd_o = 5'h00;
    // A host held in reset cannot talk, so each frame waits up to 200 cycles for the pin to rise.
    task automatic send(input logic wr, input logic [1:0] code, input logic bad);
        int n;
        n = 0;
        while (reset_out_n_i !== 1'b1 && n < 200) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        cmd_o = {1'b1, bad, wr, code};
        @(negedge clock_i);
        cmd_o = 5'h00;
    endtask
endmodule

// File: dv/pmsm_ctrl_monitor.sv
/* Concurrent checks of the mode controller's state and enables.
   Assumes it is bound to pmsm_ctrl and sees only that module's ports. */
module pmsm_ctrl_monitor
    import pmsm_pkg::*;
#(
    parameter logic [TMR_W-1:0] FS_FILTER_CYC = 26'h14
) (
    // Clock, reset and commands.
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        spi_frame_i,
    input wire logic        spi_content_bad_i,
    input wire logic        mode_wr_i,
    input wire logic [1:0]  mode_code_i,
    input wire logic        softreset_pin_suppress_i,
    input wire pmsm_cfg_t   normal_cfg_i,
    // Observed outputs.
    input wire pmsm_state_t state_o,
    input wire pmsm_en_t    enables_o,
    input wire logic        reset_out_n_o,
    input wire logic        interrupt_oe_o,
    input wire logic        wake_flags_clr_o,
    input wire logic        default_wake_en_o,
    input wire logic        command_fault_o,
    input wire logic        device_failure_o
);
    // ==========
    // Fail-safe dwell counter.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [TMR_W-1:0] fs_cnt_r;
    wire logic fs_now = state_o == PMSM_FAILSAFE;
    wire logic srst = state_o inside {PMSM_NORMAL, PMSM_STOP} && mode_wr_i && mode_code_i == 2'h3;
    wire logic [TMR_W-1:0] fs_cnt_nxt = fs_now ? fs_cnt_r + 1'b1 : '0;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fs_cnt_r <= '0;
        end else begin
            fs_cnt_r <= fs_cnt_nxt;
        end
    end
    // Bits 10..4 are regulator, watchdog, switches, bridge, amp, cyclic sense and wake.
    sleep_off_a: assert property (
        state_o == PMSM_SLEEP |-> !enables_o[10] && !enables_o[9] && enables_o[7:6] == 2'h0)
        else $error("sleep left a supply or driver on");
    sleep_keep_a: assert property (
        state_o == PMSM_SLEEP |-> enables_o.high_side_switches == normal_cfg_i.high_side_switches)
        else $error("sleep changed the switches");
    restart_rst_a: assert property (state_o == PMSM_RESTART |-> !reset_out_n_o)
        else $error("reset released in restart");
    restart_off_a: assert property (state_o == PMSM_RESTART |-> enables_o[9:4] == 6'h00)
        else $error("restart left a function on");
    fs_off_a: assert property (
        fs_now |-> enables_o[10:4] == 7'h00 && enables_o.can_wake_capable && !enables_o[0])
        else $error("fail-safe enables wrong");
    fs_entry_a: assert property (fs_now && !$past(fs_now) |-> wake_flags_clr_o && default_wake_en_o)
        else $error("fail-safe entry missed wake setup");
    fs_dwell_a: assert property (!fs_now && $past(fs_now) |-> $past(fs_cnt_r) >= FS_FILTER_CYC - 2)
        else $error("fail-safe left before filter time");
    fs_exit_a: assert property (!fs_now && $past(fs_now) |-> ##[0:1] device_failure_o)
        else $error("failure bit not set on fail-safe exit");
    init_exit_a: assert property (
        state_o == PMSM_INIT && spi_frame_i |=> state_o == PMSM_NORMAL && interrupt_oe_o
        && (!$past(spi_content_bad_i) || command_fault_o))
        else $error("init did not move to normal");
    srst_init_a: assert property (srst |=> state_o == PMSM_INIT)
        else $error("soft reset did not reach init");
    srst_pin_a: assert property (srst |=> (reset_out_n_o == softreset_pin_suppress_i)[*8])
        else $error("soft reset pin level wrong");
endmodule
bind pmsm_ctrl pmsm_ctrl_monitor #(.FS_FILTER_CYC(FS_FILTER_CYC)) u_mon (
    .clock_i, .sys_rst_i, .spi_frame_i, .spi_content_bad_i, .mode_wr_i, .mode_code_i,
    .softreset_pin_suppress_i, .normal_cfg_i, .state_o, .enables_o, .reset_out_n_o,
    .interrupt_oe_o, .wake_flags_clr_o, .default_wake_en_o, .command_fault_o,
    .device_failure_o);

// File: dv/tb_power_mode_state_machine.sv
/* Self-checking bench of the mode controller with a behavioural host.
   Assumes the host model and the bound checker are compiled first. */
module tb_power_mode_state_machine
    import pmsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Stimulus, device and checking.
    logic clock_i = 1'b0, sys_rst_i = 1'b1, wev = 0, fsf = 0, wdf = 0, rok = 1, wdo = 0, wdm = 0;
    logic sup = 0, clr = 0, brk = 1'b0, cwk = 1'b0, rf = 1'b0;
    logic [4:0] cmd;
    pmsm_cfg_t cfg = 8'hFB;
    pmsm_state_t st;
    pmsm_en_t en;
    logic rn, irqn, oe, dm, wclr, dwk, wtf, cf, df;
    int fails = 0, checks_done = 0, cyc = 0;
    always #10 clock_i = ~clock_i;
    pmsm_host_model HOST (.clock_i(clock_i), .reset_out_n_i(rn), .cmd_o(cmd));
    // Short filter times keep the run brief; the overtemperature path is left idle.
    pmsm_ctrl #(.FS_FILTER_CYC(26'h14), .OT_RECOV_CYC(26'h32)) DUT (.clock_i, .sys_rst_i,
        .devmode_strap_i(1'b1), .spi_frame_i(cmd[4]), .spi_content_bad_i(cmd[3]),
        .mode_wr_i(cmd[2]), .mode_code_i(cmd[1:0]), .normal_cfg_i(cfg),
        .softreset_pin_suppress_i(sup), .devmode_watchdog_off_i(wdo),
        .devmode_watchdog_irq_mask_i(wdm), .status_clr_i(clr), .wake_event_i(wev),
        .can_bus_wake_i(cwk), .brake_request_i(brk), .restart_fault_i(rf),
        .failsafe_fault_i(fsf), .reg_short_gnd_i(1'b0), .regulator_overtemp_shutdown_i(1'b0),
        .regulator_ok_i(rok), .wd_fault_i(wdf), .state_o(st), .enables_o(en),
        .reset_out_n_o(rn), .interrupt_out_n_o(irqn), .interrupt_oe_o(oe), .devmode_o(dm),
        .default_wake_en_o(dwk), .wake_flags_clr_o(wclr), .watchdog_trigger_fault_o(wtf),
        .command_fault_o(cf), .device_failure_o(df));
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic hit(ref logic s);
        @(negedge clock_i);
        s = 1'b1;
        @(negedge clock_i);
        s = 1'b0;
    endtask
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_devmode();
        HOST.send(1'b0, 2'h0, 1'b1);
        check(11'({st, oe, cf}), 11'({PMSM_NORMAL, 2'h3}));
        check(11'({dm, en.can_on, en.watchdog_unit}), 11'h7);
        hit(wdf);
        @(negedge clock_i);
        check(11'({st, irqn, wtf}), 11'({PMSM_NORMAL, 2'h1}));
        wdo = 1'b1;
        hit(clr);
        hit(wdf);
        @(negedge clock_i);
        check(11'({irqn, wtf, en.watchdog_unit}), 11'h4);
        wdo = 1'b0;
        wdm = 1'b1;
        hit(wdf);
        @(negedge clock_i);
        check(11'({irqn, wtf}), 11'h3);
        $display("test devmode done");
    endtask
    task automatic t_sleep();
        HOST.send(1'b1, MODE_CMD_SLEEP, 1'b0);
        rok = 1'b0;
        check(11'({st, en.high_side_switches, en.can_on, en.can_wake_capable}), 11'h1D);
        brk = 1'b1;
        @(negedge clock_i);
        check(11'({st, en.low_side_brake}), 11'({PMSM_SLEEP, 1'b1}));
        brk = 1'b0;
        hit(wev);
        check(11'({st, rn, en.high_side_switches}), 11'h10);
        rok = 1'b1;
        @(negedge clock_i);
        check(11'(st), 11'(PMSM_NORMAL));
        $display("test sleep done");
    endtask
    task automatic t_failsafe();
        int n;
        rok = 1'b0;
        hit(rf);
        check(11'({st, en.watchdog_unit, en.main_regulator}), 11'h11);
        hit(fsf);
        check(11'({st, wclr, dwk, rn}), 11'h2E);
        hit(cwk);
        check(11'(st), 11'(PMSM_FAILSAFE));
        n = 0;
        while (st !== PMSM_RESTART && n < 60) begin
            @(negedge clock_i);
            n++;
        end
        check(11'({n > 14, n < 22, df, en.can_on}), 11'hF);
        rok = 1'b1;
        $display("test fail-safe done");
    endtask
    task automatic t_softreset();
        for (int i = 0; i < 2; i++) begin
            sup = i[0];
            HOST.send(1'b1, MODE_CMD_SOFTRST, 1'b0);
            check(11'({st, rn}), 11'({PMSM_INIT, sup}));
            HOST.send(1'b0, 2'h0, 1'b0);
            check(11'(st), 11'(PMSM_NORMAL));
        end
        $display("test soft reset done");
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        t_devmode();
        t_sleep();
        t_failsafe();
        t_softreset();
        close_out();
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            close_out();
        end
    end
endmodule
